//--- src/scsc_pkg.sv
// Purpose: Shared constants and types for the system clock switch control block
// Assumes: 25 MHz block clock, eight source codes, byte-wide register port
// Notes:   Offsets are register indices on the plain register port
package scsc_pkg;

  // Widths
  localparam int SRC_W  = 3;
  localparam int DIV_W  = 4;
  localparam int NSRC   = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int TRIM_W = 6;

  // Register offsets
  localparam logic [3:0] ADDR_REQ  = 4'h0;  // clock_request_reg
  localparam logic [3:0] ADDR_CUR  = 4'h1;  // current source and divider, read only
  localparam logic [3:0] ADDR_CTRL = 4'h2;  // clock_switch_ctrl_reg
  localparam logic [3:0] ADDR_STAT = 4'h3;  // source_ready_status_reg, read only
  localparam logic [3:0] ADDR_MEN  = 4'h4;  // manual_source_enable_reg
  localparam logic [3:0] ADDR_TRIM = 4'h5;  // osc_frequency_trim
  localparam logic [3:0] ADDR_IRQS = 4'h6;  // interrupt status, write one to clear
  localparam logic [3:0] ADDR_IRQM = 4'h7;  // interrupt mask

  // Field positions
  localparam int REQ_SRC_LSB    = 4;
  localparam int REQ_DIV_LSB    = 0;
  localparam int CTRL_HOLD_BIT  = 7;
  localparam int CTRL_POLL_BIT  = 4;
  localparam int CTRL_NRDY_BIT  = 3;
  localparam int IRQ_SWDONE_BIT = 0;

  // Source codes and reset values
  localparam logic [2:0] SRC_LF    = 3'h5;
  localparam logic [2:0] SRC_HF    = 3'h6;
  localparam logic [3:0] RST_DIV   = 4'h0;
  localparam logic [5:0] TRIM_RST  = 6'h00;
  localparam logic [5:0] TRIM_SIGN = 6'h20;

  // Timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int LF_HZ           = 31_000;
  localparam int LF_DIV_CYC      = CLK_HZ / LF_HZ;
  localparam int TRIM_STEP_NS    = 1000;
  localparam int TRIM_STEP_CYC   = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_SETTLE_CYC = 2;
  localparam int BOOT_CYC        = 2;

  // Switch sequencer states
  typedef enum logic [6:0] {
    ST_BOOT     = 7'h01,
    ST_IDLE     = 7'h02,
    ST_WAIT_RDY = 7'h04,
    ST_HELD     = 7'h08,
    ST_GATE_OFF = 7'h10,
    ST_SWITCH   = 7'h20,
    ST_GATE_ON  = 7'h40
  } scsc_state_t;

endpackage

//--- src/scsc_top.sv
// Purpose: Oscillator trim, manual enables and glitch-free system clock source switching
// Assumes: Ready inputs and the reset source strap come from other domains
// Notes:   Clock gating is sequenced off, switched, then back on
//
// Summary of operation
// - Trim register resets to zero and holds a six-bit signed adjustment.
// - Trim 1Fh gives the highest frequency, 20h the lowest, signed order between.
// - A trim write starts a gradual shift; no completion flag exists.
// - The low-frequency source ignores the trim value entirely.
// - A 31 kHz low-frequency tick serves timer, watchdog and clock monitor.
// - Low-frequency source runs when the reset strap or new source selects it.
// - Per-source ready flags readable; manual enable register forces sources on.
// - Old clock stays in use until the requested source reports ready.
// - Already-running source or divider-only change counts as ready at once.
// - On ready, set new-source-ready and switch-done flag; interrupt if enabled.
// - A pollable source-ready bit shows readiness without the interrupt.
// - With hold clear, the switch happens as soon as new source is ready.
// - With hold set, the switch waits and the old clock keeps running.
// - In reduced CPU rate mode the switch takes the next clock cycle.
// - Sleep may be entered while a switch waits for its source.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module scsc_top #(
  parameter int LF_DIV = scsc_pkg::LF_DIV_CYC
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      resetn,
  // Register port
  input  wire logic [scsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [scsc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [scsc_pkg::DATA_W-1:0] reg_rdata,
  // Oscillators
  input  wire logic [scsc_pkg::NSRC-1:0]   osc_ready_async,
  input  wire logic [scsc_pkg::SRC_W-1:0]  reset_source_config,
  output logic      [scsc_pkg::NSRC-1:0]   osc_enable,
  // System clock steering
  output logic      [scsc_pkg::SRC_W-1:0]  sys_src_sel,
  output logic      [scsc_pkg::DIV_W-1:0]  sys_div_sel,
  output logic                           sys_clk_gate_en,
  output logic      [scsc_pkg::TRIM_W-1:0] hf_trim_signed,
  output logic      [scsc_pkg::TRIM_W-1:0] hf_trim_code,
  output logic                           lf_tick,
  // Power modes
  input  wire logic                      reduced_cpu_rate_mode,
  input  wire logic                      sleep_req,
  output logic                           sleep_ack,
  // Interrupt
  output logic                           irq
);

  // Synchronisers for foreign inputs
  logic [scsc_pkg::NSRC-1:0]  rdy_m_q;
  logic [scsc_pkg::NSRC-1:0]  rdy_s_q;
  logic [scsc_pkg::SRC_W-1:0] strap_m_q;
  logic [scsc_pkg::SRC_W-1:0] strap_s_q;

  // Second stage only is read by logic
  always_ff @(posedge clock) begin
    // Strap keeps sampling through reset so boot sees a settled value
    strap_m_q <= reset_source_config;
    strap_s_q <= strap_m_q;
    if (!resetn) begin
      rdy_m_q <= 8'h00;
      rdy_s_q <= 8'h00;
    end else begin
      rdy_m_q <= osc_ready_async;
      rdy_s_q <= rdy_m_q;
    end
  end

  // Control state
  scsc_pkg::scsc_state_t      state_q, state_d;
  logic [scsc_pkg::SRC_W-1:0] new_src_q, new_src_d;
  logic [scsc_pkg::DIV_W-1:0] new_div_q, new_div_d;
  logic [scsc_pkg::SRC_W-1:0] cur_src_q, cur_src_d;
  logic [scsc_pkg::DIV_W-1:0] cur_div_q, cur_div_d;
  logic [scsc_pkg::SRC_W-1:0] tgt_src_q, tgt_src_d;
  logic [scsc_pkg::DIV_W-1:0] tgt_div_q, tgt_div_d;
  logic                       hold_q, hold_d;
  logic                       nrdy_q, nrdy_d;
  logic                       gate_q, gate_d;
  logic [1:0]                 cnt_q, cnt_d;
  logic [scsc_pkg::NSRC-1:0]  men_q, men_d;
  logic                       flag_q, flag_d;
  logic                       mask_q, mask_d;
  logic [scsc_pkg::NSRC-1:0]  en_q, en_d;
  logic                       irq_q, irq_d;
  logic                       slp_q, slp_d;
  logic [scsc_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic [scsc_pkg::TRIM_W-1:0] trim_reg_q, trim_reg_d;
  logic [scsc_pkg::TRIM_W-1:0] trim_now_q, trim_now_d;
  logic [scsc_pkg::TRIM_W-1:0] trim_code_q, trim_code_d;
  logic [4:0]                  step_cnt_q, step_cnt_d;
  logic                       req_pending;
  logic                       new_rdy;
  logic                       rdy_evt;
  logic                       poll_rdy;

  // Pending if source or divider differs; copying current back abandons
  assign req_pending = (new_src_q != cur_src_q) || (new_div_q != cur_div_q);
  // Same source, or one already running, is ready straight away
  assign new_rdy  = req_pending && ((new_src_q == cur_src_q) || rdy_s_q[new_src_q]);
  assign poll_rdy = (new_src_q == cur_src_q) || rdy_s_q[new_src_q];
  assign rdy_evt  = (state_q == scsc_pkg::ST_WAIT_RDY) && new_rdy;

  // Register writes, switch sequencer, flags and reads
  always_comb begin
    state_d   = state_q;
    new_src_d = new_src_q;
    new_div_d = new_div_q;
    cur_src_d = cur_src_q;
    cur_div_d = cur_div_q;
    tgt_src_d = tgt_src_q;
    tgt_div_d = tgt_div_q;
    hold_d    = hold_q;
    nrdy_d    = nrdy_q;
    gate_d    = gate_q;
    cnt_d     = cnt_q;
    men_d     = men_q;
    mask_d    = mask_q;
    flag_d    = flag_q;
    rdata_d   = 8'h00;
    // Software writes
    if (reg_wr) begin
      case (reg_addr)
        scsc_pkg::ADDR_REQ: begin
          new_src_d = reg_wdata[scsc_pkg::REQ_SRC_LSB +: scsc_pkg::SRC_W];
          new_div_d = reg_wdata[scsc_pkg::REQ_DIV_LSB +: scsc_pkg::DIV_W];
        end
        scsc_pkg::ADDR_CTRL: hold_d = reg_wdata[scsc_pkg::CTRL_HOLD_BIT];
        scsc_pkg::ADDR_MEN:  men_d  = reg_wdata;
        scsc_pkg::ADDR_IRQS: begin
          if (reg_wdata[scsc_pkg::IRQ_SWDONE_BIT]) begin
            flag_d = 1'b0;
          end
        end
        scsc_pkg::ADDR_IRQM: mask_d = reg_wdata[scsc_pkg::IRQ_SWDONE_BIT];
        default: ;
      endcase
    end
    // Sequencer
    case (state_q)
      scsc_pkg::ST_BOOT: begin
        // Strap is only trusted once both synchroniser stages are filled
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == 2'(scsc_pkg::BOOT_CYC - 1)) begin
          cur_src_d = strap_s_q;
          new_src_d = strap_s_q;
          cnt_d     = 2'h0;
          state_d   = scsc_pkg::ST_IDLE;
        end
      end
      scsc_pkg::ST_IDLE: begin
        if (req_pending) begin
          state_d = scsc_pkg::ST_WAIT_RDY;
        end
      end
      scsc_pkg::ST_WAIT_RDY: begin
        // Old clock stays selected while waiting; sleep is not blocked
        if (!req_pending) begin
          state_d = scsc_pkg::ST_IDLE;
        end else if (new_rdy) begin
          nrdy_d    = 1'b1;
          tgt_src_d = new_src_q;
          tgt_div_d = new_div_q;
          state_d   = hold_q ? scsc_pkg::ST_HELD : scsc_pkg::ST_GATE_OFF;
        end
      end
      scsc_pkg::ST_HELD: begin
        tgt_src_d = new_src_q;
        tgt_div_d = new_div_q;
        if (!req_pending) begin
          nrdy_d  = 1'b0;
          state_d = scsc_pkg::ST_IDLE;
        end else if (!hold_q) begin
          state_d = scsc_pkg::ST_GATE_OFF;
        end
      end
      scsc_pkg::ST_GATE_OFF: begin
        // Gate low for settle cycles so no clipped pulse reaches the core
        gate_d = 1'b0;
        cnt_d  = cnt_q + 2'h1;
        if (reduced_cpu_rate_mode || (cnt_q == 2'(scsc_pkg::GATE_SETTLE_CYC - 1))) begin
          cnt_d   = 2'h0;
          state_d = scsc_pkg::ST_SWITCH;
        end
      end
      scsc_pkg::ST_SWITCH: begin
        cur_src_d = tgt_src_q;
        cur_div_d = tgt_div_q;
        nrdy_d    = 1'b0;
        state_d   = scsc_pkg::ST_GATE_ON;
      end
      scsc_pkg::ST_GATE_ON: begin
        gate_d  = 1'b1;
        state_d = scsc_pkg::ST_IDLE;
      end
      default: state_d = scsc_pkg::ST_IDLE;
    endcase
    // A ready event beats a same-cycle clear
    if (rdy_evt) begin
      flag_d = 1'b1;
    end
    // Read mux, answer registered for the next cycle
    if (reg_rd) begin
      case (reg_addr)
        scsc_pkg::ADDR_REQ:  rdata_d = {1'b0, new_src_q, new_div_q};
        scsc_pkg::ADDR_CUR:  rdata_d = {1'b0, cur_src_q, cur_div_q};
        scsc_pkg::ADDR_CTRL: begin
          rdata_d[scsc_pkg::CTRL_HOLD_BIT] = hold_q;
          rdata_d[scsc_pkg::CTRL_POLL_BIT] = poll_rdy;
          rdata_d[scsc_pkg::CTRL_NRDY_BIT] = nrdy_q;
        end
        scsc_pkg::ADDR_STAT: rdata_d = rdy_s_q;
        scsc_pkg::ADDR_MEN:  rdata_d = men_q;
        scsc_pkg::ADDR_TRIM: rdata_d = {2'b00, trim_reg_q};
        scsc_pkg::ADDR_IRQS: rdata_d[scsc_pkg::IRQ_SWDONE_BIT] = flag_q;
        scsc_pkg::ADDR_IRQM: rdata_d[scsc_pkg::IRQ_SWDONE_BIT] = mask_q;
        default:             rdata_d = 8'h00;
      endcase
    end
    // Enables: manual, current, and whatever is requested
    en_d  = men_q | (8'h01 << cur_src_d) | (8'h01 << new_src_d);
    irq_d = flag_d && mask_d;
    slp_d = sleep_req;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q   <= scsc_pkg::ST_BOOT;
      new_src_q <= scsc_pkg::SRC_HF;
      new_div_q <= scsc_pkg::RST_DIV;
      cur_src_q <= scsc_pkg::SRC_HF;
      cur_div_q <= scsc_pkg::RST_DIV;
      tgt_src_q <= scsc_pkg::SRC_HF;
      tgt_div_q <= scsc_pkg::RST_DIV;
      hold_q    <= 1'b0;
      nrdy_q    <= 1'b0;
      gate_q    <= 1'b1;
      cnt_q     <= 2'h0;
      men_q     <= 8'h00;
      flag_q    <= 1'b0;
      mask_q    <= 1'b0;
      en_q      <= 8'h00;
      irq_q     <= 1'b0;
      slp_q     <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      state_q   <= state_d;
      new_src_q <= new_src_d;
      new_div_q <= new_div_d;
      cur_src_q <= cur_src_d;
      cur_div_q <= cur_div_d;
      tgt_src_q <= tgt_src_d;
      tgt_div_q <= tgt_div_d;
      hold_q    <= hold_d;
      nrdy_q    <= nrdy_d;
      gate_q    <= gate_d;
      cnt_q     <= cnt_d;
      men_q     <= men_d;
      flag_q    <= flag_d;
      mask_q    <= mask_d;
      en_q      <= en_d;
      irq_q     <= irq_d;
      slp_q     <= slp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Trim register; applied value walks one step at a time, nothing reports arrival
  always_comb begin
    trim_reg_d = trim_reg_q;
    trim_now_d = trim_now_q;
    step_cnt_d = step_cnt_q + 5'h01;
    if (reg_wr && (reg_addr == scsc_pkg::ADDR_TRIM)) begin
      trim_reg_d = reg_wdata[scsc_pkg::TRIM_W-1:0];
    end
    if (step_cnt_q == 5'(scsc_pkg::TRIM_STEP_CYC - 1)) begin
      step_cnt_d = 5'h00;
      if ($signed(trim_now_q) < $signed(trim_reg_q)) begin
        trim_now_d = trim_now_q + 6'h01;
      end else if ($signed(trim_now_q) > $signed(trim_reg_q)) begin
        trim_now_d = trim_now_q - 6'h01;
      end
    end
    // Offset binary so 1Fh maps highest and 20h lowest
    trim_code_d = trim_now_d ^ scsc_pkg::TRIM_SIGN;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      trim_reg_q  <= scsc_pkg::TRIM_RST;
      trim_now_q  <= scsc_pkg::TRIM_RST;
      trim_code_q <= scsc_pkg::TRIM_SIGN;
      step_cnt_q  <= 5'h00;
    end else begin
      trim_reg_q  <= trim_reg_d;
      trim_now_q  <= trim_now_d;
      trim_code_q <= trim_code_d;
      step_cnt_q  <= step_cnt_d;
    end
  end

  // Low-frequency time base, independent of any trim
  logic [9:0] lf_cnt_q, lf_cnt_d;
  logic       lf_tick_q, lf_tick_d;

  always_comb begin
    lf_cnt_d  = lf_cnt_q + 10'h001;
    lf_tick_d = 1'b0;
    if (lf_cnt_q == 10'(LF_DIV - 1)) begin
      lf_cnt_d  = 10'h000;
      lf_tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lf_cnt_q  <= 10'h000;
      lf_tick_q <= 1'b0;
    end else begin
      lf_cnt_q  <= lf_cnt_d;
      lf_tick_q <= lf_tick_d;
    end
  end

  // Outputs, all straight from flops
  assign reg_rdata       = rdata_q;
  assign osc_enable      = en_q;
  assign sys_src_sel     = cur_src_q;
  assign sys_div_sel     = cur_div_q;
  assign sys_clk_gate_en = gate_q;
  assign hf_trim_signed  = trim_now_q;
  assign hf_trim_code    = trim_code_q;
  assign lf_tick         = lf_tick_q;
  assign sleep_ack       = slp_q;
  assign irq             = irq_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_ready_seen;
    rdy_evt && !hold_q;
  endsequence

  sequence s_gate_then_switch;
    (state_q == scsc_pkg::ST_GATE_OFF) ##[1:2] (state_q == scsc_pkg::ST_SWITCH);
  endsequence

  a_trim_single_step: assert property (
    (trim_now_q != $past(trim_now_q)) |->
      ((6'(trim_now_q - $past(trim_now_q)) == 6'h01) ||
       (6'(trim_now_q - $past(trim_now_q)) == 6'h3F)))
    else $error("trim moved more than one step");
  a_trim_code_order: assert property (
    (trim_now_q == 6'h1F) |-> (hf_trim_code == 6'h3F))
    else $error("highest trim not highest code");
  a_lf_tick_spacing: assert property (
    lf_tick |=> (!lf_tick) [*8])
    else $error("low frequency tick too close");
  a_lf_enable_on: assert property (
    (new_src_d == scsc_pkg::SRC_LF) |=> osc_enable[scsc_pkg::SRC_LF])
    else $error("low frequency source not enabled");
  a_old_clock_kept: assert property (
    ((state_q == scsc_pkg::ST_WAIT_RDY) && !new_rdy) |=> $stable(sys_src_sel) && sys_clk_gate_en)
    else $error("clock changed before ready");
  a_ready_sets_flags: assert property (
    rdy_evt |=> flag_q && nrdy_q ##1 (irq == mask_q || !flag_q))
    else $error("ready did not set flags");
  a_hold_suspends: assert property (
    ((state_q == scsc_pkg::ST_HELD) && hold_q) |=> sys_clk_gate_en && $stable(sys_src_sel))
    else $error("held switch progressed");
  a_switch_prompt: assert property (
    s_ready_seen |=> s_gate_then_switch)
    else $error("switch not prompt after ready");
  a_reduced_cpu_rate_mode_next_cycle: assert property (
    ((state_q == scsc_pkg::ST_GATE_OFF) && reduced_cpu_rate_mode) |=>
      (state_q == scsc_pkg::ST_SWITCH))
    else $error("reduced_cpu_rate_mode switch not on next cycle");
  a_switch_updates: assert property (
    (state_q == scsc_pkg::ST_SWITCH) |=>
      (sys_src_sel == $past(tgt_src_q)) && !sys_clk_gate_en ##1 sys_clk_gate_en)
    else $error("current fields or gate wrong at switch");
  a_sleep_in_wait: assert property (
    ((state_q == scsc_pkg::ST_WAIT_RDY) && sleep_req) |=> sleep_ack)
    else $error("sleep refused while waiting");

endmodule
`default_nettype wire

//--- tb/scsc_osc_model.sv
// Purpose: Behavioural oscillator bank facing the clock switch block
// Assumes: One ready level per source code, settling counted in block clocks
// Notes:   Ready drops at once when the enable goes away, as a stopped oscillator would
`timescale 1ns/1ns
`default_nettype none
module scsc_osc_model #(
  parameter int SLOW_CYC = 40,
  parameter int FAST_CYC = 4
) (
  // Clock
  input  wire logic                        clock,
  // Enables in, readiness out
  input  wire logic [scsc_pkg::NSRC-1:0] osc_enable,
  output var  logic [scsc_pkg::NSRC-1:0] osc_ready_async
);
  int cnt [scsc_pkg::NSRC];

  initial osc_ready_async = 8'h00;

  // Low and high internal sources settle slowly so waits are seen
  always @(posedge clock) begin
    for (int i = 0; i < scsc_pkg::NSRC; i++) begin
      if (osc_enable[i] !== 1'b1) begin
        cnt[i] <= 0;
        osc_ready_async[i] <= 1'b0;
      end else if (cnt[i] >= ((i >= 5) ? SLOW_CYC : FAST_CYC)) begin
        osc_ready_async[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/system_clock_switch_control_bench.sv
// Purpose: Self-checking bench for the clock switch control block
// Assumes: Register port with one-cycle strobes, oscillator model on the far side
// Notes:   Low-frequency divider shortened to 12 so tick spacing is cheap to measure
`timescale 1ns/1ns
`default_nettype none
module system_clock_switch_control_bench;
  localparam int LF_DIV = 12;
  localparam int LIMIT  = 20000;

  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] osc_ready_async;
  logic [2:0] reset_source_config = 3'h6;
  logic [7:0] osc_enable;
  logic [2:0] sys_src_sel;
  logic [3:0] sys_div_sel;
  logic       sys_clk_gate_en;
  logic [5:0] hf_trim_signed;
  logic [5:0] hf_trim_code;
  logic       lf_tick;
  logic       reduced_cpu_rate_mode = 1'b0;
  logic       sleep_req = 1'b0;
  logic       sleep_ack;
  logic       irq;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         n_norm;
  int         n_reduced_cpu_rate_mode;
  int         gap;
  logic       seen;

  // 25 MHz clock
  always #20 clock = ~clock;

  scsc_top #(.LF_DIV(LF_DIV)) u_dut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_ready_async(osc_ready_async), .reset_source_config(reset_source_config),
    .osc_enable(osc_enable), .sys_src_sel(sys_src_sel), .sys_div_sel(sys_div_sel),
    .sys_clk_gate_en(sys_clk_gate_en), .hf_trim_signed(hf_trim_signed),
    .hf_trim_code(hf_trim_code), .lf_tick(lf_tick),
    .reduced_cpu_rate_mode(reduced_cpu_rate_mode), .sleep_req(sleep_req),
    .sleep_ack(sleep_ack), .irq(irq));

  scsc_osc_model u_osc (
    .clock(clock), .osc_enable(osc_enable), .osc_ready_async(osc_ready_async));

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Settle past the edge before looking at outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  task automatic do_reset(input logic [2:0] strap);
    @(posedge clock);
    reset_source_config <= strap;
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    cyc(3);
  endtask

  task automatic wait_src(input logic [2:0] s);
    for (int i = 0; i < 300 && sys_src_sel !== s; i++)
      cyc(1);
    chk("sys_src_sel", {5'h00, s}, {5'h00, sys_src_sel});
  endtask

  // Count gate-low cycles and irq activity around one request
  task automatic do_switch(input logic [7:0] req, output int low, output logic hit);
    wr(scsc_pkg::ADDR_REQ, req);
    low = 0;
    hit = 1'b0;
    repeat (60) begin
      cyc(1);
      if (sys_clk_gate_en === 1'b0) low++;
      if (irq === 1'b1) hit = 1'b1;
    end
  endtask

  initial begin
    // Reset values and register map
    do_reset(3'h6);
    chk("src", 8'h06, {5'h00, sys_src_sel});
    chk("trim_code", 8'h20, {2'h0, hf_trim_code});
    rchk(scsc_pkg::ADDR_REQ, 8'h60, "req");
    rchk(scsc_pkg::ADDR_TRIM, 8'h00, "trim");
    rchk(scsc_pkg::ADDR_MEN, 8'h00, "men");
    rchk(scsc_pkg::ADDR_IRQM, 8'h00, "irqm");
    wr(scsc_pkg::ADDR_CUR, 8'hFF);
    rchk(scsc_pkg::ADDR_CUR, 8'h60, "cur_ro");
    wr(4'h8, 8'hFF);
    rchk(4'h8, 8'h00, "unmapped");
    $display("test reset done");

    // Manual enable and ready status
    wr(scsc_pkg::ADDR_MEN, 8'h01);
    cyc(2);
    chk("osc_enable0", 8'h01, {7'h00, osc_enable[0]});
    cyc(50);
    rchk(scsc_pkg::ADDR_STAT, 8'h41, "stat");
    wr(scsc_pkg::ADDR_MEN, 8'h00);
    $display("test manual done");

    // Trim ramps gradually, extremes, tick unaffected
    wr(scsc_pkg::ADDR_TRIM, 8'h1F);
    rchk(scsc_pkg::ADDR_TRIM, 8'h1F, "trim_rd");
    chk("trim_early", 8'h01, {7'h00, hf_trim_signed !== 6'h1F});
    cyc(900);
    chk("trim_hi", 8'h3F, {2'h0, hf_trim_code});
    wr(scsc_pkg::ADDR_TRIM, 8'h20);
    for (int i = 0; i < 100 && lf_tick !== 1'b1; i++)
      cyc(1);
    gap = 0;
    do begin
      cyc(1);
      gap++;
    end while (lf_tick !== 1'b1 && gap < 100);
    chk("lf_gap", 8'(LF_DIV), 8'(gap));
    cyc(1700);
    chk("trim_lo", 8'h00, {2'h0, hf_trim_code});
    chk("trim_sgn", 8'h20, {2'h0, hf_trim_signed});
    $display("test trim done");

    // Divider-only change, interrupt unmasked
    wr(scsc_pkg::ADDR_IRQM, 8'h01);
    do_switch(8'h63, n_norm, seen);
    chk("irq_seen", 8'h01, {7'h00, seen});
    chk("div", 8'h03, {4'h0, sys_div_sel});
    rchk(scsc_pkg::ADDR_CUR, 8'h63, "cur");
    rchk(scsc_pkg::ADDR_IRQS, 8'h01, "flag");
    wr(scsc_pkg::ADDR_IRQS, 8'h01);
    cyc(1);
    chk("irq_clr", 8'h00, {7'h00, irq});
    rchk(scsc_pkg::ADDR_IRQS, 8'h00, "flag_clr");
    $display("test divider done");

    // Reduced rate mode shortens the switch, masked interrupt stays low
    wr(scsc_pkg::ADDR_IRQM, 8'h00);
    reduced_cpu_rate_mode <= 1'b1;
    do_switch(8'h60, n_reduced_cpu_rate_mode, seen);
    @(posedge clock);
    reduced_cpu_rate_mode <= 1'b0;
    chk("gate_diff", 8'h01, 8'(n_norm - n_reduced_cpu_rate_mode));
    chk("irq_masked", 8'h00, {7'h00, seen});
    rchk(scsc_pkg::ADDR_IRQS, 8'h01, "flag_m");
    wr(scsc_pkg::ADDR_IRQS, 8'h01);
    $display("test reduced_cpu_rate_mode done");

    // Slow source: old clock kept, sleep allowed while waiting
    wr(scsc_pkg::ADDR_REQ, 8'h50);
    sleep_req <= 1'b1;
    cyc(10);
    chk("lf_en", 8'h01, {7'h00, osc_enable[5]});
    chk("src_old", 8'h06, {5'h00, sys_src_sel});
    chk("sleep_ack", 8'h01, {7'h00, sleep_ack});
    rchk(scsc_pkg::ADDR_CTRL, 8'h00, "ctrl_wait");
    @(posedge clock);
    sleep_req <= 1'b0;
    wait_src(3'h5);
    rchk(scsc_pkg::ADDR_CUR, 8'h50, "cur_lf");
    wr(scsc_pkg::ADDR_IRQS, 8'h01);
    $display("test slow done");

    // Held switch, then released
    wr(scsc_pkg::ADDR_CTRL, 8'h80);
    wr(scsc_pkg::ADDR_REQ, 8'h60);
    cyc(70);
    rchk(scsc_pkg::ADDR_CTRL, 8'h98, "ctrl_held");
    chk("src_held", 8'h05, {5'h00, sys_src_sel});
    wr(scsc_pkg::ADDR_CTRL, 8'h00);
    wait_src(3'h6);
    // Held switch abandoned by copying current into request
    wr(scsc_pkg::ADDR_CTRL, 8'h80);
    wr(scsc_pkg::ADDR_REQ, 8'h50);
    cyc(70);
    rchk(scsc_pkg::ADDR_CTRL, 8'h98, "ctrl_held2");
    wr(scsc_pkg::ADDR_REQ, 8'h60);
    cyc(20);
    rchk(scsc_pkg::ADDR_CTRL, 8'h90, "ctrl_aband");
    chk("src_kept", 8'h06, {5'h00, sys_src_sel});
    wr(scsc_pkg::ADDR_CTRL, 8'h00);
    $display("test hold done");

    // Strap selects the low-frequency source at reset
    do_reset(3'h5);
    cyc(2);
    chk("strap_src", 8'h05, {5'h00, sys_src_sel});
    chk("strap_en", 8'h01, {7'h00, osc_enable[5]});
    $display("test strap done");
    complete_run();
  end
endmodule
`default_nettype wire
